// [include/split_timer_pkg.sv]
// ****************************************
// split auto-reload timer constants
// ****************************************
package split_timer_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CLOCK = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_RELOAD = 8'h0c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;

    // timer_control_reg field positions
    localparam int CTL_HIGH_FLAG = 7;
    localparam int CTL_LOW_FLAG = 6;
    localparam int CTL_LOW_IRQ_EN = 5;
    localparam int CTL_CAPTURE_EN = 4;
    localparam int CTL_SPLIT = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_CAPTURE_SRC = 1;
    localparam int CTL_EXT_CLK = 0;

    // clock_control_reg field positions
    localparam int CLK_LOW_SEL = 0;
    localparam int CLK_HIGH_SEL = 1;

    // interrupt status / enable / clear layout
    localparam int IRQ_HIGH = 0;
    localparam int IRQ_LOW = 1;
    localparam int IRQ_CAPTURE = 2;
    localparam int IRQ_W = 3;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [1:0] CLOCK_RESET = 2'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // prescaler ratios
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [core/clock_tick_gen.sv]
`timescale 1ns/1ps
// ****************************************
// prescaler ticks
// ****************************************
module clock_tick_gen #(
    parameter int SYS_DIV = split_timer_pkg::SYS_DIV,
    parameter int EXT_DIV = split_timer_pkg::EXT_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_osc,
    output logic div12_tick,
    output logic ext8_tick
);
    localparam int SW = $clog2(SYS_DIV);
    localparam int EW = $clog2(EXT_DIV);
    localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
    localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);

    logic [SW-1:0] sys_cnt_reg;
    logic [EW-1:0] ext_cnt_reg;
    logic ext_meta_reg;
    logic ext_sync_reg;
    logic ext_prev_reg;
    logic ext_rise;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_cnt_reg <= '0;
            div12_tick <= 1'b0;
        end else begin
            div12_tick <= (sys_cnt_reg == SYS_LAST); // R3
            sys_cnt_reg <= (sys_cnt_reg == SYS_LAST) ? '0 : sys_cnt_reg + 1'b1;
        end
    end

    // oscillator pin is asynchronous: two flops before any logic looks at it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= ext_osc; // R4
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    assign ext_rise = ext_sync_reg & ~ext_prev_reg;

    // oscillator must run below aclk/2 for every edge to be seen
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_cnt_reg <= '0;
            ext8_tick <= 1'b0;
        end else begin
            ext8_tick <= ext_rise && (ext_cnt_reg == EXT_LAST); // R3 R4
            if (ext_rise) begin
                ext_cnt_reg <= (ext_cnt_reg == EXT_LAST) ? '0 : ext_cnt_reg + 1'b1;
            end
        end
    end

endmodule // clock_tick_gen

// [core/split_autoreload_timer.sv]
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// R1 - two 8-bit bytes form one 16-bit count
// R2 - split and capture clear: 16-bit auto-reload
// R3 - clocks: system, system/12, external/8
// R4 - external/8 clock synchronised to system clock
// R5 - 16-bit overflow reloads, sets high flag
// R6 - 16-bit overflow raises interrupt when enabled
// R7 - low byte rollover interrupts if enabled
// R8 - split: two 8-bit auto-reload counters
// R9 - split: run gates high byte only
// R10 - per-byte select: system else divided clock
// R11 - split: each byte rollover sets its flag
// R12 - split: high interrupts, low if enabled
// R13 - flags cleared only by software write
// R14 - software reads both flags, clears them
// R15 - capture copies count into reload registers
// R16 - 16-bit mode counts only while run set
module split_autoreload_timer #(
    parameter int SYS_DIV = split_timer_pkg::SYS_DIV,
    parameter int EXT_DIV = split_timer_pkg::EXT_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [split_timer_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [split_timer_pkg::DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [split_timer_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [split_timer_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ext_osc,
    input wire logic low_freq_oscillator,
    input wire logic sof_pulse,
    output logic irq
);

    // ****************************************
    // declarations
    // ****************************************
    logic [7:0] timer_control_reg;
    logic [1:0] clock_control_reg;
    logic [7:0] count_low_byte_reg;
    logic [7:0] count_high_byte_reg;
    logic [7:0] reload_low_byte_reg;
    logic [7:0] reload_high_byte_reg;
    logic [split_timer_pkg::IRQ_W-1:0] irq_status_reg;
    logic [split_timer_pkg::IRQ_W-1:0] irq_enable_reg;

    logic aw_full_reg;
    logic w_full_reg;
    logic [split_timer_pkg::ADDR_W-1:0] waddr_reg;
    logic [split_timer_pkg::DATA_W-1:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic do_write;
    logic addr_hit;
    logic [split_timer_pkg::DATA_W-1:0] rdata_next;
    logic rresp_err;

    logic wr_control;
    logic wr_clock;
    logic wr_count;
    logic wr_reload;
    logic wr_irq_enable;
    logic wr_irq_clear;

    logic split_mode_select;
    logic capture_enable;
    logic capture_source_select;
    logic run_control;
    logic external_clock_select;
    logic low_overflow_irq_enable;
    logic low_byte_clock_select;
    logic high_byte_clock_select;

    logic div12_tick;
    logic ext8_tick;
    logic low_tick;
    logic high_tick;
    logic adv_low;
    logic adv_high;
    logic low_ovf;
    logic high_ovf;
    logic reload_low_now;
    logic reload_high_now;

    logic lfo_meta_reg;
    logic lfo_sync_reg;
    logic lfo_prev_reg;
    logic capture_evt;
    logic [split_timer_pkg::IRQ_W-1:0] irq_events;

    // ****************************************
    // control fields
    // ****************************************
    assign split_mode_select = timer_control_reg[split_timer_pkg::CTL_SPLIT];
    assign capture_enable = timer_control_reg[split_timer_pkg::CTL_CAPTURE_EN];
    assign capture_source_select = timer_control_reg[split_timer_pkg::CTL_CAPTURE_SRC];
    assign run_control = timer_control_reg[split_timer_pkg::CTL_RUN];
    assign external_clock_select = timer_control_reg[split_timer_pkg::CTL_EXT_CLK];
    assign low_overflow_irq_enable = timer_control_reg[split_timer_pkg::CTL_LOW_IRQ_EN];
    assign low_byte_clock_select = clock_control_reg[split_timer_pkg::CLK_LOW_SEL];
    assign high_byte_clock_select = clock_control_reg[split_timer_pkg::CLK_HIGH_SEL];

    // ****************************************
    // clock sources
    // ****************************************
    clock_tick_gen #(
        .SYS_DIV(SYS_DIV),
        .EXT_DIV(EXT_DIV)
    ) u_ticks (
        .aclk(aclk),
        .aresetn(aresetn),
        .ext_osc(ext_osc),
        .div12_tick(div12_tick),
        .ext8_tick(ext8_tick)
    );

    // 16-bit mode takes its clock from the low byte select
    assign low_tick = low_byte_clock_select ? 1'b1
        : (external_clock_select ? ext8_tick : div12_tick); // R10 R3
    assign high_tick = high_byte_clock_select ? 1'b1
        : (external_clock_select ? ext8_tick : div12_tick); // R10

    // ****************************************
    // counting
    // ****************************************
    assign adv_low = split_mode_select ? low_tick : (run_control && low_tick); // R9 R16
    assign adv_high = split_mode_select ? (run_control && high_tick)
        : (adv_low && count_low_byte_reg == 8'hff); // R9 R1
    assign low_ovf = adv_low && (count_low_byte_reg == 8'hff); // R7 R11
    assign high_ovf = adv_high && (count_high_byte_reg == 8'hff); // R5 R11
    // capture mode wraps to zero instead of reloading
    assign reload_low_now = !capture_enable
        && (split_mode_select ? low_ovf : high_ovf); // R8 R5 R2
    assign reload_high_now = !capture_enable && high_ovf; // R8 R5

    // software write to the count beats a same-cycle increment
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_low_byte_reg <= split_timer_pkg::BYTE_RESET;
        end else if (wr_count && wstrb_reg[0]) begin
            count_low_byte_reg <= wdata_reg[7:0];
        end else if (reload_low_now) begin
            count_low_byte_reg <= reload_low_byte_reg; // R5 R8
        end else if (adv_low) begin
            count_low_byte_reg <= count_low_byte_reg + 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_high_byte_reg <= split_timer_pkg::BYTE_RESET;
        end else if (wr_count && wstrb_reg[1]) begin
            count_high_byte_reg <= wdata_reg[15:8];
        end else if (reload_high_now) begin
            count_high_byte_reg <= reload_high_byte_reg; // R5 R8
        end else if (adv_high) begin
            count_high_byte_reg <= count_high_byte_reg + 8'h01;
        end
    end

    // ****************************************
    // capture
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfo_meta_reg <= 1'b0;
            lfo_sync_reg <= 1'b0;
            lfo_prev_reg <= 1'b0;
        end else begin
            lfo_meta_reg <= low_freq_oscillator;
            lfo_sync_reg <= lfo_meta_reg;
            lfo_prev_reg <= lfo_sync_reg;
        end
    end

    assign capture_evt = capture_enable && (capture_source_select
        ? (lfo_sync_reg && !lfo_prev_reg) : sof_pulse); // R15

    // a capture beats a same-cycle software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_low_byte_reg <= split_timer_pkg::BYTE_RESET;
            reload_high_byte_reg <= split_timer_pkg::BYTE_RESET;
        end else if (capture_evt) begin
            reload_low_byte_reg <= count_low_byte_reg; // R15
            reload_high_byte_reg <= count_high_byte_reg; // R15
        end else if (wr_reload) begin
            if (wstrb_reg[0]) begin
                reload_low_byte_reg <= wdata_reg[7:0];
            end
            if (wstrb_reg[1]) begin
                reload_high_byte_reg <= wdata_reg[15:8];
            end
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    // hardware set is written last so it wins over a clearing write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_control_reg <= split_timer_pkg::CONTROL_RESET;
        end else begin
            if (wr_control && wstrb_reg[0]) begin
                timer_control_reg <= wdata_reg[7:0]; // R13 R14
            end
            if (high_ovf) begin
                timer_control_reg[split_timer_pkg::CTL_HIGH_FLAG] <= 1'b1; // R5 R11
            end
            if (low_ovf) begin
                timer_control_reg[split_timer_pkg::CTL_LOW_FLAG] <= 1'b1; // R11
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_control_reg <= split_timer_pkg::CLOCK_RESET;
        end else if (wr_clock && wstrb_reg[0]) begin
            clock_control_reg <= wdata_reg[1:0]; // R10
        end
    end

    // ****************************************
    // interrupts
    // ****************************************
    always_comb begin
        irq_events = '0;
        irq_events[split_timer_pkg::IRQ_HIGH] = high_ovf; // R6 R12
        irq_events[split_timer_pkg::IRQ_LOW] = low_ovf && low_overflow_irq_enable; // R7 R12
        irq_events[split_timer_pkg::IRQ_CAPTURE] = capture_evt; // R15
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= split_timer_pkg::IRQ_RESET;
        end else begin
            irq_status_reg <= (irq_status_reg
                & ~((wr_irq_clear && wstrb_reg[0]) ? wdata_reg[split_timer_pkg::IRQ_W-1:0] : '0))
                | irq_events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_enable_reg <= split_timer_pkg::IRQ_RESET;
        end else if (wr_irq_enable && wstrb_reg[0]) begin
            irq_enable_reg <= wdata_reg[split_timer_pkg::IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status_reg & irq_enable_reg); // R6 R7 R12

    // ****************************************
    // axi4-lite write
    // ****************************************
    assign awready = !aw_full_reg && !bvalid;
    assign wready = !w_full_reg && !bvalid;
    assign do_write = aw_full_reg && w_full_reg && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            waddr_reg <= '0;
        end else if (awvalid && awready) begin
            aw_full_reg <= 1'b1;
            waddr_reg <= awaddr;
        end else if (do_write) begin
            aw_full_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg <= 1'b0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else if (wvalid && wready) begin
            w_full_reg <= 1'b1;
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
        end else if (do_write) begin
            w_full_reg <= 1'b0;
        end
    end

    assign wr_control = do_write && waddr_reg[7:2] == split_timer_pkg::OFF_CONTROL[7:2];
    assign wr_clock = do_write && waddr_reg[7:2] == split_timer_pkg::OFF_CLOCK[7:2];
    assign wr_count = do_write && waddr_reg[7:2] == split_timer_pkg::OFF_COUNT[7:2];
    assign wr_reload = do_write && waddr_reg[7:2] == split_timer_pkg::OFF_RELOAD[7:2];
    assign wr_irq_enable = do_write && waddr_reg[7:2] == split_timer_pkg::OFF_IRQ_ENABLE[7:2];
    assign wr_irq_clear = do_write && waddr_reg[7:2] == split_timer_pkg::OFF_IRQ_CLEAR[7:2];
    assign addr_hit = wr_control || wr_clock || wr_count || wr_reload
        || wr_irq_enable || wr_irq_clear;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= split_timer_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp <= addr_hit ? split_timer_pkg::RESP_OKAY : split_timer_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ****************************************
    // axi4-lite read
    // ****************************************
    assign arready = !rvalid;

    always_comb begin
        rdata_next = '0;
        rresp_err = 1'b0;
        unique case (araddr[7:2])
            split_timer_pkg::OFF_CONTROL[7:2]: rdata_next[7:0] = timer_control_reg;
            split_timer_pkg::OFF_CLOCK[7:2]: rdata_next[1:0] = clock_control_reg;
            split_timer_pkg::OFF_COUNT[7:2]: rdata_next[15:0] = {count_high_byte_reg, count_low_byte_reg};
            split_timer_pkg::OFF_RELOAD[7:2]: rdata_next[15:0] = {reload_high_byte_reg, reload_low_byte_reg};
            split_timer_pkg::OFF_IRQ_STATUS[7:2]: rdata_next[split_timer_pkg::IRQ_W-1:0] = irq_status_reg;
            split_timer_pkg::OFF_IRQ_ENABLE[7:2]: rdata_next[split_timer_pkg::IRQ_W-1:0] = irq_enable_reg;
            split_timer_pkg::OFF_IRQ_CLEAR[7:2]: rdata_next = '0;
            default: rresp_err = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= split_timer_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rdata_next;
            rresp <= rresp_err ? split_timer_pkg::RESP_SLVERR : split_timer_pkg::RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule // split_autoreload_timer

// [tb/split_timer_properties.sv]
`timescale 1ns/1ps
module split_timer_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************
    // bus handshakes
    // ****************************************
    a_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_rvalid_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read response dropped early");
    a_arready_busy: assert property (arready == !rvalid)
        else $error("read ready wrong");
    a_write_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
        else $error("write response late");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read response late");
    // 0x19 to 0x1b still decode to the clear word, so the refused range starts at 0x1c
    a_unmapped_read: assert property (arvalid && arready && araddr > 8'h1b |=> rresp == 2'h2 && rdata == 32'h0)
        else $error("unmapped read not refused");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !irq)
        else $error("outputs active after reset");
    // ****************************************
    // interrupt
    // ****************************************
    // the line drops only through a committed software write
    a_irq_sticky: assert property ($fell(irq) |-> bvalid)
        else $error("interrupt dropped without write");
endmodule // split_timer_properties

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] CTL = split_timer_pkg::OFF_CONTROL;
    localparam logic [7:0] CLK = split_timer_pkg::OFF_CLOCK;
    localparam logic [7:0] CNT = split_timer_pkg::OFF_COUNT;
    localparam logic [7:0] RLD = split_timer_pkg::OFF_RELOAD;
    localparam logic [7:0] STS = split_timer_pkg::OFF_IRQ_STATUS;
    localparam logic [7:0] IEN = split_timer_pkg::OFF_IRQ_ENABLE;
    localparam logic [7:0] CLR = split_timer_pkg::OFF_IRQ_CLEAR;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic ext_osc = 0, low_freq_oscillator = 0, sof_pulse = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rr, last_bresp;
    int error_cnt = 0, check_count = 0, osc_cnt = 0;
    split_autoreload_timer dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_osc(ext_osc),
        .low_freq_oscillator(low_freq_oscillator), .sof_pulse(sof_pulse), .irq(irq));
    always #10 aclk = ~aclk;
    // free-running slow sources, unrelated to the bus traffic
    always @(posedge aclk) begin
        osc_cnt <= osc_cnt + 1;
        if (osc_cnt % 3 == 2) ext_osc <= ~ext_osc;
        if (osc_cnt % 10 == 9) low_freq_oscillator <= ~low_freq_oscillator;
    end
    // ****************************************
    // helpers
    // ****************************************
    task finish_test;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task in_range(input string name, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
        check(name, 32'h1, 32'(got >= lo && got <= hi));
    endtask
    task wait_cycles(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // ready is sampled mid-cycle, so the release lands just after the taking edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, done;
        done = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = (bvalid === 1'b1);
            last_bresp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (done) bready <= 0;
        end
        if (!done) begin
            error_cnt++;
            finish_test();
        end
    endtask
    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, got;
        got = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            got = (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 0;
            if (got) rready <= 0;
        end
        if (!got) begin
            error_cnt++;
            finish_test();
        end
    endtask
    task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, rd, rr);
        check(name, exp, rd);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        for (int i = 0; i < 8; i++) begin
            axi_read(8'(i * 4), rd, rr);
            check("reset_data", 32'h0, rd);
            check("reset_resp", i < 7 ? 32'h0 : 32'h2, {30'h0, rr});
        end
        wr(8'h1c, 32'hffff);
        check("unmapped_write", 32'h2, {30'h0, last_bresp});
    endtask
    task t_sixteen;
        wr(CLK, 32'h1);
        wr(CNT, 32'hffff);
        wr(RLD, 32'h1234);
        wr(IEN, 32'h3);
        wait_cycles(10);
        rchk("held_count", CNT, 32'hffff);
        wr(CTL, 32'h24);
        wait_cycles(4);
        rchk("flags_16", CTL, 32'he4);
        axi_read(CNT, rd, rr);
        in_range("reload_16", 32'h1234, 32'h1250, rd);
        rchk("status_16", STS, 32'h3);
        check("irq_16", 32'h1, irq);
        wr(CTL, 32'he0);
        wait_cycles(20);
        check("irq_sticky", 32'h1, irq);
        rchk("flags_kept", CTL, 32'he0);
        wr(CTL, 32'h0);
        wr(CLR, 32'h7);
        check("irq_cleared", 32'h0, irq);
        rchk("status_clr", STS, 32'h0);
    endtask
    task t_split;
        wr(CLK, 32'h3);
        wr(CNT, 32'h40f0);
        wr(RLD, 32'h7710);
        wr(IEN, 32'h1);
        wr(CTL, 32'h08);
        wait_cycles(40);
        axi_read(CNT, rd, rr);
        check("split_high_held", 32'h40, rd[15:8]);
        in_range("split_low_reload", 32'h10, 32'h50, rd[7:0]);
        rchk("split_low_flag", CTL, 32'h48);
        check("split_no_irq", 32'h0, irq);
        wr(CTL, 32'h2c);
        wait_cycles(250);
        rchk("split_flags", CTL, 32'hec);
        axi_read(CNT, rd, rr);
        in_range("split_high_reload", 32'h77, 32'hd0, rd[15:8]);
        rchk("split_status", STS, 32'h3);
        check("split_irq", 32'h1, irq);
        wr(CTL, 32'h0);
        wr(CLR, 32'h7);
    endtask
    task t_divided;
        wr(CLK, 32'h0);
        wr(CNT, 32'h0);
        wr(CTL, 32'h04);
        wait_cycles(240);
        axi_read(CNT, rd, rr);
        in_range("div12_count", 32'd18, 32'd22, rd);
        wr(CTL, 32'h0);
        wr(CNT, 32'h0);
        wr(CTL, 32'h05);
        wait_cycles(480);
        axi_read(CNT, rd, rr);
        in_range("ext8_count", 32'd8, 32'd12, rd);
        wr(CTL, 32'h0);
        // high byte on its own divided select, only reachable in split mode
        wr(CNT, 32'h0);
        wr(CTL, 32'h0c);
        wait_cycles(240);
        axi_read(CNT, rd, rr);
        in_range("split_div12_high", 32'd18, 32'd22, rd[15:8]);
        wr(CTL, 32'h0);
    endtask
    task t_capture;
        for (int src = 0; src < 2; src++) begin
            wr(CNT, 32'h0);
            wr(RLD, 32'h0);
            wr(CLR, 32'h7);
            wr(IEN, 32'h4);
            wr(CLK, 32'h1);
            wr(CTL, 32'h14 | 32'(src << 1));
            wait_cycles(30);
            if (src == 0) begin
                @(posedge aclk) sof_pulse <= 1;
                @(posedge aclk) sof_pulse <= 0;
            end
            wait_cycles(30);
            wr(CTL, 32'h0);
            axi_read(RLD, rd, rr);
            in_range("capture_value", 32'h1, 32'h80, rd);
            rchk("capture_status", STS, 32'h4);
            check("capture_irq", 32'h1, irq);
            wr(CLR, 32'h7);
        end
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        t_reset();
        t_sixteen();
        t_split();
        t_divided();
        t_capture();
        finish_test();
    end
endmodule // testbench
bind split_autoreload_timer split_timer_properties chk_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq));
